// ===== design/adc_reset_defines.vh
// constants for the converter reset and power-state block
`ifndef ADC_RESET_DEFINES_VH
`define ADC_RESET_DEFINES_VH

// ==================================================================
// register offsets
`define REG_CFG_A         4'h0
`define REG_DEV_CFG       4'h1
`define REG_DIAG          4'h2
`define REG_IRQ_STATUS    4'h3
`define REG_IRQ_CLEAR     4'h4
`define REG_IRQ_ENABLE    4'h5
`define REG_STATE         4'h6

// ==================================================================
// field positions
`define SOFT_RESET_A_BIT  7
`define SOFT_RESET_B_BIT  0
`define RESET_SEEN_BIT    0
`define PWR_FIELD_LO      0
`define PWR_FIELD_HI      1

// ==================================================================
// reset values and encodings
`define PWR_NORMAL        2'h0
`define PWR_SHUTDOWN      2'h3
`define DEV_CFG_RESET     8'h00
`define IRQ_EN_RESET      4'h0

// interrupt bits
`define IRQ_RESET         0
`define IRQ_CONV_DONE     1
`define IRQ_CONV_IGNORED  2
`define IRQ_POR           3

// ==================================================================
// timing
`define CLK_PERIOD_NS     40
`define BLACKOUT_US       750
`define BLACKOUT_CYCLES   ((`BLACKOUT_US * 1000) / `CLK_PERIOD_NS)
`define CONV_CYCLES_DEF   16

`endif

// ===== design/blackout_timer.v
// counts out the post-reset blackout period
`timescale 1ns/1ns
module blackout_timer #(
    parameter BLACKOUT_CYCLES = 18750
) (
    input  wire        mclk_i,
    input  wire        reset_n_i,
    input  wire        start_i,
    output reg         active_o
);
    reg [31:0] count_r;

    always @(posedge mclk_i) begin
        if (!reset_n_i) begin
            count_r  <= 32'h0;
            active_o <= 1'b0;
        end else if (start_i) begin
            count_r  <= BLACKOUT_CYCLES - 1;
            active_o <= 1'b1;
        end else if (count_r != 32'h0) begin
            count_r  <= count_r - 32'h1;
        end else begin
            active_o <= 1'b0;
        end
    end
endmodule // blackout_timer

// ===== design/conversion_engine.v
// conversion timing: start edge, busy, done
`timescale 1ns/1ns
module conversion_engine #(
    parameter CONV_CYCLES = 16
) (
    input  wire        mclk_i,
    input  wire        reset_n_i,
    input  wire        convert_start_i,
    input  wire        enable_i,
    output reg         busy_o,
    output reg         sample_o,
    output reg         done_o,
    output reg         ignored_o
);
    reg        start_d_r;
    reg [15:0] count_r;
    wire       rise;
    wire [31:0] conv_load;

    assign rise = convert_start_i & ~start_d_r;
    // parameter arithmetic is 32 bits wide; the counter keeps the low half
    assign conv_load = CONV_CYCLES - 1;

    always @(posedge mclk_i) begin
        if (!reset_n_i) begin
            start_d_r <= 1'b0;
            count_r   <= 16'h0;
            busy_o    <= 1'b0;
            sample_o  <= 1'b0;
            done_o    <= 1'b0;
            ignored_o <= 1'b0;
        end else begin
            start_d_r <= convert_start_i;
            sample_o  <= 1'b0;
            done_o    <= 1'b0;
            ignored_o <= 1'b0;
            if (busy_o) begin
                if (count_r == 16'h0) begin
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                end else begin
                    count_r <= count_r - 16'h1;
                end
            end else if (rise) begin
                if (enable_i) begin
                    sample_o <= 1'b1;
                    busy_o   <= 1'b1;
                    count_r  <= conv_load[15:0];
                end else begin
                    ignored_o <= 1'b1;
                end
            end
        end
    end
endmodule // conversion_engine

// ===== design/adc_reset_and_power_state.v
// reset and power-state controller for a sar converter
//
// Function
// - low pulse on reset pin resets the device
// - soft reset only when both soft reset bits written 1 together
// - hardware or soft reset sets the sticky reset-seen flag
// - writing 1 clears reset-seen flag; writing 0 keeps it
// - power-on reset restores configuration and sets reset-seen flag
// - power-on reset at supply rise and whenever a supply sags
// - analog inputs sampled at rising edge of convert start
// - after conversion, enter standby; reference buffer stays on
// - writing 0x3 to power-state field enters shutdown
// - power-state field resets to normal operating mode
// - busy rises on conversion start and falls when it finishes
//
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/1ns
`include "adc_reset_defines.vh"
module adc_reset_and_power_state (
    input  wire        mclk_i,
    input  wire        reset_n_i,
    input  wire        hard_reset_n_i,
    input  wire        supply_good_i,
    input  wire        convert_start_i,
    input  wire [3:0]  addr_i,
    input  wire [7:0]  wdata_i,
    input  wire        wr_i,
    input  wire        rd_i,
    output reg  [7:0]  rdata_o,
    output reg         busy_or_clock_out_o,
    output reg         sample_o,
    output reg         standby_o,
    output reg         shutdown_o,
    output reg         ref_buffer_on_o,
    output reg         blackout_o,
    output reg         irq_o
);
    // ==================================================================
    // reset sources
    reg        supply_d_r;
    reg        hard_d_r;
    reg        por_r;
    reg        hard_evt_r;
    reg        soft_evt_r;
    wire       por_now;
    wire       hard_edge;
    wire       soft_req;
    wire       blk_active;

    // any loss of supply is a power-on reset; on return it fires again
    assign por_now   = ~supply_good_i;
    assign hard_edge = hard_d_r & ~hard_reset_n_i;
    assign soft_req  = wr_i && !blk_active && (addr_i == `REG_CFG_A) &&
                       wdata_i[`SOFT_RESET_A_BIT] && wdata_i[`SOFT_RESET_B_BIT];

    always @(posedge mclk_i) begin
        if (!reset_n_i) begin
            supply_d_r <= 1'b0;
            hard_d_r   <= 1'b1;
            por_r      <= 1'b1;
            hard_evt_r <= 1'b0;
            soft_evt_r <= 1'b0;
        end else begin
            supply_d_r <= supply_good_i;
            hard_d_r   <= hard_reset_n_i;
            por_r      <= por_now | (supply_good_i & ~supply_d_r);
            hard_evt_r <= hard_edge;
            soft_evt_r <= soft_req;
        end
    end

    // ==================================================================
    // blackout and conversion
    wire       conv_busy;
    wire       conv_sample;
    wire       conv_done;
    wire       conv_ignored;
    wire       cfg_shutdown;
    reg  [1:0] pwr_state_r;

    blackout_timer #(
        .BLACKOUT_CYCLES (`BLACKOUT_CYCLES)
    ) u_blackout (
        .mclk_i    (mclk_i),
        .reset_n_i (reset_n_i),
        .start_i   (hard_evt_r | soft_evt_r),
        .active_o  (blk_active)
    );

    assign cfg_shutdown = (pwr_state_r == `PWR_SHUTDOWN);

    conversion_engine #(
        .CONV_CYCLES (`CONV_CYCLES_DEF)
    ) u_conv (
        .mclk_i          (mclk_i),
        .reset_n_i       (reset_n_i & ~por_r),
        .convert_start_i (convert_start_i),
        .enable_i        (~blk_active & ~cfg_shutdown & ~por_r),
        .busy_o          (conv_busy),
        .sample_o        (conv_sample),
        .done_o          (conv_done),
        .ignored_o       (conv_ignored)
    );

    // ==================================================================
    // registers
    reg        reset_seen_r;
    reg  [3:0] irq_status_r;
    reg  [3:0] irq_enable_r;
    reg  [3:0] irq_set;
    reg        reg_wr;
    reg        seen_set;

    always @* begin
        // register access refused during blackout
        reg_wr   = wr_i & ~blk_active;
        seen_set = hard_evt_r | soft_evt_r | por_r;
        irq_set  = 4'h0;
        irq_set[`IRQ_RESET]        = hard_evt_r | soft_evt_r;
        irq_set[`IRQ_CONV_DONE]    = conv_done;
        irq_set[`IRQ_CONV_IGNORED] = conv_ignored;
        irq_set[`IRQ_POR]          = por_r;
    end

    always @(posedge mclk_i) begin
        if (!reset_n_i) begin
            pwr_state_r  <= `PWR_NORMAL;
            reset_seen_r <= 1'b1;
            irq_status_r <= 4'h0;
            irq_enable_r <= `IRQ_EN_RESET;
        end else begin
            if (por_r) begin
                pwr_state_r  <= `PWR_NORMAL;
                irq_enable_r <= `IRQ_EN_RESET;
            end else if (soft_evt_r | hard_evt_r) begin
                pwr_state_r <= `PWR_NORMAL;
            end else if (reg_wr && addr_i == `REG_DEV_CFG) begin
                pwr_state_r <= wdata_i[`PWR_FIELD_HI:`PWR_FIELD_LO];
            end else if (reg_wr && addr_i == `REG_IRQ_ENABLE) begin
                irq_enable_r <= wdata_i[3:0];
            end
            // set wins over a clear in the same cycle
            if (seen_set)
                reset_seen_r <= 1'b1;
            else if (reg_wr && addr_i == `REG_DIAG && wdata_i[`RESET_SEEN_BIT])
                reset_seen_r <= 1'b0;
            if (reg_wr && addr_i == `REG_IRQ_CLEAR)
                irq_status_r <= (irq_status_r & ~wdata_i[3:0]) | irq_set;
            else
                irq_status_r <= irq_status_r | irq_set;
        end
    end

    // ==================================================================
    // read port and outputs
    reg  [7:0] rd_mux;

    always @* begin
        rd_mux = 8'h00;
        if (addr_i == `REG_DEV_CFG)
            rd_mux[`PWR_FIELD_HI:`PWR_FIELD_LO] = pwr_state_r;
        else if (addr_i == `REG_DIAG)
            rd_mux[`RESET_SEEN_BIT] = reset_seen_r;
        else if (addr_i == `REG_IRQ_STATUS)
            rd_mux[3:0] = irq_status_r;
        else if (addr_i == `REG_IRQ_ENABLE)
            rd_mux[3:0] = irq_enable_r;
        else if (addr_i == `REG_STATE)
            rd_mux[3:0] = {blk_active, cfg_shutdown, conv_busy, por_r};
    end

    always @(posedge mclk_i) begin
        if (!reset_n_i) begin
            rdata_o             <= 8'h00;
            busy_or_clock_out_o <= 1'b1;
            sample_o            <= 1'b0;
            standby_o           <= 1'b0;
            shutdown_o          <= 1'b0;
            ref_buffer_on_o     <= 1'b1;
            blackout_o          <= 1'b0;
            irq_o               <= 1'b0;
        end else begin
            // reads during blackout return zero
            rdata_o             <= (rd_i && !blk_active) ? rd_mux : 8'h00;
            busy_or_clock_out_o <= conv_busy | blk_active | por_r;
            sample_o            <= conv_sample;
            standby_o           <= ~conv_busy & ~cfg_shutdown;
            shutdown_o          <= cfg_shutdown;
            // buffer kept alive in standby, off only in shutdown
            ref_buffer_on_o     <= ~cfg_shutdown;
            blackout_o          <= blk_active;
            irq_o               <= |(irq_status_r & irq_enable_r);
        end
    end
endmodule // adc_reset_and_power_state

// ===== test/adc_reset_and_power_state_asserts.sv
// assertion checker for the reset and power-state block
`timescale 1ns/1ns
module adc_reset_and_power_state_asserts (
    input logic       mclk_i,
    input logic       reset_n_i,
    input logic       hard_reset_n_i,
    input logic       supply_good_i,
    input logic       convert_start_i,
    input logic [3:0] addr_i,
    input logic [7:0] wdata_i,
    input logic       wr_i,
    input logic       rd_i,
    input logic [7:0] rdata_o,
    input logic       busy_or_clock_out_o,
    input logic       sample_o,
    input logic       standby_o,
    input logic       shutdown_o,
    input logic       ref_buffer_on_o,
    input logic       blackout_o,
    input logic       irq_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);
    // ==========
    // helpers
    logic [15:0] blk_cnt_r;
    wire         wr_cfg = wr_i && addr_i == 4'h0 && !busy_or_clock_out_o;
    // counts blackout length so the full 750 us can be judged at its end
    always @(posedge mclk_i) blk_cnt_r <= (reset_n_i && blackout_o) ? blk_cnt_r + 16'h0001 : 16'h0000;
    sequence s_busy8; busy_or_clock_out_o [*8]; endsequence
    // write edge, event flop, timer flop, output flop: visible three edges on
    property p_soft; wr_cfg && wdata_i[7] && wdata_i[0] |-> ##3 blackout_o; endproperty
    property p_one; wr_cfg && (wdata_i[7] ^ wdata_i[0]) |-> ##3 !blackout_o; endproperty
    property p_hard; $fell(hard_reset_n_i) && !busy_or_clock_out_o |-> ##[1:4] blackout_o; endproperty
    property p_len; $fell(blackout_o) |-> blk_cnt_r == 16'h493E; endproperty
    property p_cover; blackout_o |-> busy_or_clock_out_o; endproperty
    property p_rdblk; blackout_o && $past(blackout_o) && $past(rd_i) |-> rdata_o == 8'h00; endproperty
    property p_conv; $rose(convert_start_i) && !busy_or_clock_out_o && !shutdown_o
        |-> ##2 (sample_o && busy_or_clock_out_o); endproperty
    property p_busy; sample_o |-> s_busy8 ##1 s_busy8 ##[1:2] !busy_or_clock_out_o; endproperty
    property p_stby; $fell(busy_or_clock_out_o) && !shutdown_o
        |-> ##[0:1] (standby_o && ref_buffer_on_o); endproperty
    property p_shut; wr_i && addr_i == 4'h1 && wdata_i[1:0] == 2'h3 && !blackout_o
        |-> ##[1:2] (shutdown_o && !ref_buffer_on_o); endproperty
    property p_por; !supply_good_i |-> ##3 !shutdown_o; endproperty
    a_soft: assert property (p_soft) else $error("soft reset missed");
    a_one: assert property (p_one) else $error("single bit reset");
    a_hard: assert property (p_hard) else $error("pin reset missed");
    a_len: assert property (p_len) else $error("blackout length wrong");
    a_cover: assert property (p_cover) else $error("blackout not busy");
    a_rdblk: assert property (p_rdblk) else $error("read served in blackout");
    a_conv: assert property (p_conv) else $error("start edge not taken");
    a_busy: assert property (p_busy) else $error("busy length wrong");
    a_stby: assert property (p_stby) else $error("no standby after conversion");
    a_shut: assert property (p_shut) else $error("shutdown not entered");
    a_por: assert property (p_por) else $error("power-on reset kept config");
endmodule // adc_reset_and_power_state_asserts
bind adc_reset_and_power_state adc_reset_and_power_state_asserts u_adc_reset_and_power_state_asserts (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .hard_reset_n_i(hard_reset_n_i),
    .supply_good_i(supply_good_i), .convert_start_i(convert_start_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .busy_or_clock_out_o(busy_or_clock_out_o), .sample_o(sample_o), .standby_o(standby_o),
    .shutdown_o(shutdown_o), .ref_buffer_on_o(ref_buffer_on_o), .blackout_o(blackout_o),
    .irq_o(irq_o));

// ===== test/host_model.sv
// host controller model: reset pin, supplies and convert start
`timescale 1ns/1ns
module host_model #(
    parameter SETTLE_CYCLES = 75000
) (
    input  logic mclk_i,
    input  logic busy_i,
    output logic hard_reset_n_o,
    output logic supply_good_o,
    output logic convert_start_o
);
    initial begin
        hard_reset_n_o = 1'b1;
        supply_good_o = 1'b0;
        convert_start_o = 1'b0;
    end
    // ==========
    // host actions
    task automatic power_up();
        supply_good_o <= 1'b1;
        repeat (SETTLE_CYCLES) @(posedge mclk_i);
    endtask
    task automatic pulse_reset();
        @(posedge mclk_i) hard_reset_n_o <= 1'b0;
        repeat (2) @(posedge mclk_i); // 80 ns, above the minimum width
        hard_reset_n_o <= 1'b1;
    endtask
    // blackout shows three cycles after the pin falls, so wait before watching busy
    task automatic wait_quiet();
        repeat (4) @(posedge mclk_i);
        repeat (20000) if (busy_i) @(posedge mclk_i);
    endtask
    task automatic convert();
        @(posedge mclk_i) convert_start_o <= 1'b1;
        repeat (2) @(posedge mclk_i);
        convert_start_o <= 1'b0;
    endtask
    task automatic dip();
        @(posedge mclk_i) supply_good_o <= 1'b0;
        repeat (3) @(posedge mclk_i);
        supply_good_o <= 1'b1;
    endtask
endmodule // host_model

// ===== test/adc_reset_and_power_state_test.sv
// self-checking bench for the reset and power-state block
`timescale 1ns/1ns
module adc_reset_and_power_state_test;
    logic       mclk_i = 1'b0;
    logic       reset_n_i = 1'b0;
    logic       hard_reset_n_i, supply_good_i, convert_start_i;
    logic [3:0] addr_i = 4'h0;
    logic [7:0] wdata_i = 8'h00;
    logic       wr_i = 1'b0;
    logic       rd_i = 1'b0;
    logic [7:0] rdata_o;
    logic       busy_or_clock_out_o, sample_o, standby_o, shutdown_o, ref_buffer_on_o;
    logic       blackout_o, irq_o;
    int         errors = 0;
    int         checked = 0;
    always #20 mclk_i = ~mclk_i;
    adc_reset_and_power_state u_adc_reset_and_power_state (.*);
    host_model #(.SETTLE_CYCLES(100)) u_host_model (.mclk_i(mclk_i),
        .busy_i(busy_or_clock_out_o), .hard_reset_n_o(hard_reset_n_i),
        .supply_good_o(supply_good_i), .convert_start_o(convert_start_i));
    // ==========
    // bus and compare tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge mclk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1 chk(rdata_o, exp);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    // ==========
    // scenarios
    task automatic t_hard();
        wr(4'h2, 8'h01);
        rd(4'h2, 8'h00);
        u_host_model.pulse_reset();
        u_host_model.wait_quiet();
        rd(4'h2, 8'h01);
        wr(4'h2, 8'h00);
        rd(4'h2, 8'h01);
        wr(4'h2, 8'h01);
        rd(4'h2, 8'h00);
    endtask
    task automatic t_soft();
        wr(4'h0, 8'h80);
        wr(4'h0, 8'h01);
        settle(3);
        chk({7'h00, blackout_o}, 8'h00);
        wr(4'h4, 8'h0F);
        wr(4'h0, 8'h81);
        settle(3);
        chk({7'h00, blackout_o}, 8'h01);
        u_host_model.convert();
        rd(4'h2, 8'h00);
        u_host_model.wait_quiet();
        rd(4'h2, 8'h01);
        rd(4'h3, 8'h05);
    endtask
    task automatic t_conv_irq();
        wr(4'h4, 8'h0F);
        wr(4'h5, 8'h02);
        u_host_model.convert();
        settle(20);
        chk({5'h00, standby_o, ref_buffer_on_o, irq_o}, 8'h07);
        wr(4'h5, 8'h00);
        settle(2);
        chk({7'h00, irq_o}, 8'h00);
        wr(4'h5, 8'h02);
        wr(4'h4, 8'h02);
        settle(2);
        chk({7'h00, irq_o}, 8'h00);
        rd(4'h3, 8'h00);
        rd(4'hF, 8'h00);
    endtask
    task automatic t_power();
        wr(4'h1, 8'h03);
        settle(2);
        chk({6'h00, shutdown_o, ref_buffer_on_o}, 8'h02);
        u_host_model.convert();
        settle(2);
        chk({7'h00, busy_or_clock_out_o}, 8'h00);
        rd(4'h1, 8'h03);
        wr(4'h2, 8'h01);
        u_host_model.dip();
        settle(3);
        rd(4'h1, 8'h00);
        rd(4'h2, 8'h01);
        rd(4'h5, 8'h00);
        rd(4'h3, 8'h0C);
        u_host_model.pulse_reset();
        u_host_model.wait_quiet();
    endtask
    task automatic conclude();
        $display("errors=%0d checked=%0d", errors, checked);
        if (errors == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        u_host_model.power_up();
        t_hard();
        t_soft();
        t_conv_irq();
        t_power();
        conclude();
    end
    initial begin
        #(90000 * 40);
        errors++;
        conclude();
    end
endmodule // adc_reset_and_power_state_test
